//--- rtl/isohp_top.sv
// Isochronous stream header path: receive stripping and filtering, transmit insertion
`timescale 1ns/1ps
module isohp_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Receive configuration
   input  wire logic        timestamp_strip_enable,
   input  wire logic        iso_header_strip,
   input  wire logic        first_cip_strip,
   input  wire logic        second_cip_strip,
   input  wire logic [1:0]  stream_format_select,
   input  wire logic [1:0]  receive_filter_select,
   input  wire logic [31:0] receive_filter_config_a,
   input  wire logic [31:0] receive_filter_config_b,
   // Receive stream from link
   input  wire logic        rx_valid,
   input  wire logic [31:0] rx_data,
   input  wire logic        rx_sop,
   input  wire logic        rx_eop,
   // Buffer write side
   output logic             buf_wr_valid,
   output logic [31:0]      buf_wr_data,
   output logic             buf_wr_eop,
   output logic             buf_wr_half,
   output logic             rx_pkt_dropped,
   // Transmit configuration
   input  wire logic        header_insert_mode,
   input  wire logic        dv_pal_select,
   input  wire logic [31:0] tx_iso_header,
   input  wire logic [31:0] tx_cip0,
   input  wire logic [31:0] tx_cip1,
   input  wire logic        dif_header_word_a_wr,
   input  wire logic        dif_header_word_b_wr,
   input  wire logic [31:0] dif_header_wdata,
   // Transmit application side
   input  wire logic        tx_start,
   input  wire logic        app_valid,
   input  wire logic [31:0] app_data,
   output logic             app_ready,
   // Transmit link side
   output logic             tx_valid,
   output logic [31:0]      tx_data,
   output logic             tx_sop,
   output logic             tx_eop,
   output logic [3:0]       dif_sequence_id
);
   import isohp_pkg::*;

   // ==========================================================
   // Receive state
   logic [2:0]  in_idx_q, in_idx_d;
   logic [2:0]  cur_idx;
   logic        s_v_q, s_v_d;
   logic [31:0] s_dat_q, s_dat_d;
   logic        s_eop_q, s_eop_d;
   logic [2:0]  s_idx_q, s_idx_d;
   logic        pass_q, pass_d;
   logic [15:0] hold_q, hold_d;
   logic        flush_q, flush_d;
   logic        w_v_q, w_v_d;
   logic [31:0] w_dat_q, w_dat_d;
   logic        w_eop_q, w_eop_d;
   logic        w_half_q, w_half_d;
   logic        drop_q, drop_d;
   logic        proc;
   logic        is_sat;
   logic        is_130;
   logic        ts_ok;
   logic        strip;
   logic        shifted;
   logic        keep;
   logic        filt_ok;
   logic        tag_ok;
   logic [31:0] fq;
   logic [31:0] fmask;

   // ==========================================================
   // Packet position and one-quadlet look-ahead stage
   always_comb
   begin
      cur_idx  = rx_sop ? IDX_ISO : in_idx_q;
      in_idx_d = in_idx_q;
      if (rx_valid)
         in_idx_d = (cur_idx == IDX_SHIFT) ? IDX_SHIFT : cur_idx + 3'h1;
      proc    = s_v_q && (rx_valid || s_eop_q);
      s_v_d   = s_v_q;
      s_dat_d = s_dat_q;
      s_eop_d = s_eop_q;
      s_idx_d = s_idx_q;
      if (rx_valid)
      begin
         s_v_d   = 1'b1;
         s_dat_d = rx_data;
         s_eop_d = rx_eop;
         s_idx_d = cur_idx;
      end
      else if (proc)
         s_v_d = 1'b0;
   end

   // ==========================================================
   // Packet filter, decided on the first quadlet; source ID mode reads the second
   always_comb
   begin
      fq    = s_dat_q;
      fmask = HDR0_FIELD;
      case (receive_filter_select)
         FLT_SID:
         begin
            fq    = rx_data;
            fmask = SID_FIELD;
         end
         FLT_LEN:
            fmask = LEN_FIELD;
         FLT_HDR0:
            fmask = HDR0_FIELD;
         default:
            fmask = 32'h00000000;
      endcase
      filt_ok = (((fq ^ receive_filter_config_a) & fmask & ~receive_filter_config_b) == 32'h00000000);
      tag_ok  = (stream_format_select != FMT_DV) || (s_dat_q[TAG_LSB +: 2] == TAG_DV);
   end

   // ==========================================================
   // Header stripping and realignment
   always_comb
   begin
      is_sat  = (stream_format_select == FMT_SAT140) || (stream_format_select == FMT_SAT130);
      is_130  = (stream_format_select == FMT_SAT130);
      ts_ok   = timestamp_strip_enable && iso_header_strip && first_cip_strip && second_cip_strip;
      case (s_idx_q)
         IDX_ISO:    strip = iso_header_strip;
         IDX_CIP0:   strip = first_cip_strip;
         IDX_CIP1:   strip = second_cip_strip;
         IDX_TS:     strip = is_sat && ts_ok;
         IDX_SATH_A: strip = is_130;
         IDX_SATH_B: strip = is_130;
         default:    strip = 1'b0;
      endcase
      shifted = is_130 && (s_idx_q >= IDX_SPLIT);
      keep    = (s_idx_q == IDX_ISO) ? (filt_ok && tag_ok) : pass_q;
      pass_d  = pass_q;
      drop_d  = 1'b0;
      if (proc && (s_idx_q == IDX_ISO))
      begin
         pass_d = filt_ok && tag_ok;
         drop_d = !(filt_ok && tag_ok);
      end
   end

   // ==========================================================
   // Buffer write stage
   always_comb
   begin
      hold_d   = hold_q;
      flush_d  = 1'b0;
      w_v_d    = 1'b0;
      w_dat_d  = w_dat_q;
      w_eop_d  = 1'b0;
      w_half_d = 1'b0;
      if (flush_q)
      begin
         w_v_d    = 1'b1;
         w_dat_d  = {hold_q, 16'h0000};
         w_eop_d  = 1'b1;
         w_half_d = 1'b1;
      end
      else if (proc && keep && !strip)
      begin
         if (shifted)
         begin
            hold_d  = s_dat_q[15:0];
            flush_d = s_eop_q;
            if (s_idx_q == IDX_SHIFT)
            begin
               w_v_d   = 1'b1;
               w_dat_d = {hold_q, s_dat_q[31:16]};
            end
         end
         else
         begin
            w_v_d   = 1'b1;
            w_dat_d = s_dat_q;
            w_eop_d = s_eop_q;
         end
      end
   end

   // ==========================================================
   // Receive registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         in_idx_q <= IDX_ISO;
         s_v_q    <= 1'b0;
         s_dat_q  <= 32'h00000000;
         s_eop_q  <= 1'b0;
         s_idx_q  <= IDX_ISO;
         pass_q   <= 1'b0;
         hold_q   <= 16'h0000;
         flush_q  <= 1'b0;
         w_v_q    <= 1'b0;
         w_dat_q  <= 32'h00000000;
         w_eop_q  <= 1'b0;
         w_half_q <= 1'b0;
         drop_q   <= 1'b0;
      end
      else
      begin
         in_idx_q <= in_idx_d;
         s_v_q    <= s_v_d;
         s_dat_q  <= s_dat_d;
         s_eop_q  <= s_eop_d;
         s_idx_q  <= s_idx_d;
         pass_q   <= pass_d;
         hold_q   <= hold_d;
         flush_q  <= flush_d;
         w_v_q    <= w_v_d;
         w_dat_q  <= w_dat_d;
         w_eop_q  <= w_eop_d;
         w_half_q <= w_half_d;
         drop_q   <= drop_d;
      end
   end

   assign buf_wr_valid   = w_v_q;
   assign buf_wr_data    = w_dat_q;
   assign buf_wr_eop     = w_eop_q;
   assign buf_wr_half    = w_half_q;
   assign rx_pkt_dropped = drop_q;

   // ==========================================================
   // Transmit path
   isohp_tx_if txi ();

   assign txi.insert_mode = header_insert_mode;
   assign txi.fmt         = stream_format_select;
   assign txi.pal         = dv_pal_select;
   assign txi.iso_hdr     = tx_iso_header;
   assign txi.cip0        = tx_cip0;
   assign txi.cip1        = tx_cip1;
   assign txi.word_a_wr   = dif_header_word_a_wr;
   assign txi.word_b_wr   = dif_header_word_b_wr;
   assign txi.word_data   = dif_header_wdata;
   assign txi.start       = tx_start;
   assign txi.app_valid   = app_valid;
   assign txi.app_data    = app_data;

   isohp_tx_insert u_tx (
      .clk   (clk),
      .rst_n (rst_n),
      .t     (txi.core)
   );

   assign app_ready       = txi.app_ready;
   assign tx_valid        = txi.tx_valid;
   assign tx_data         = txi.tx_data;
   assign tx_sop          = txi.tx_sop;
   assign tx_eop          = txi.tx_eop;
   assign dif_sequence_id = txi.seq;
endmodule

//--- rtl/isohp_pkg.sv
// Constants and types for the isochronous stream header path
// Behaviour
// - Remove the source-packet time stamp from received satellite packets when enabled and all three header strips are on.
// - Separate strips for iso header, first and second CIP quadlets.
// - 130-byte satellite format drops its 10-byte transport header automatically.
// - Filter packets on source ID, length or header zero, with mask bits.
// - Buffer fed here is read by the data port or host access port.
// - DV transmit inserts an 80-byte header block once every 25 packets.
// - Header block starts with two programmable words reset zero, rest 0xff.
// - Sequence number advances every 25 packets and goes in the header.
// - Sequence wraps to zero after 9 for NTSC, 11 for PAL.
// - A stopped source does not clear the sequence counter.
// - Inserted packet: iso header, two CIP, 80-byte block, 400 data bytes.
// - Received DV: iso header tag 01, two CIP quadlets, 480 data bytes.
// - Header insert mode adds iso, CIP and format headers on transmit.
package isohp_pkg;
   // ==========================================================
   // Formats and filter modes
   localparam logic [1:0]  FMT_DV      = 2'h0;
   localparam logic [1:0]  FMT_SAT140  = 2'h1;
   localparam logic [1:0]  FMT_SAT130  = 2'h2;
   localparam logic [1:0]  FLT_OFF     = 2'h0;
   localparam logic [1:0]  FLT_SID     = 2'h1;
   localparam logic [1:0]  FLT_LEN     = 2'h2;
   localparam logic [1:0]  FLT_HDR0    = 2'h3;
   localparam logic [31:0] SID_FIELD   = 32'h3f000000;
   localparam logic [31:0] LEN_FIELD   = 32'hffff0000;
   localparam logic [31:0] HDR0_FIELD  = 32'hffffffff;
   localparam int          TAG_LSB     = 14;
   localparam logic [1:0]  TAG_DV      = 2'h1;
   // ==========================================================
   // Receive quadlet positions
   localparam logic [2:0]  IDX_ISO     = 3'h0;
   localparam logic [2:0]  IDX_CIP0    = 3'h1;
   localparam logic [2:0]  IDX_CIP1    = 3'h2;
   localparam logic [2:0]  IDX_TS      = 3'h3;
   localparam logic [2:0]  IDX_SATH_A  = 3'h4;
   localparam logic [2:0]  IDX_SATH_B  = 3'h5;
   localparam logic [2:0]  IDX_SPLIT   = 3'h6;
   localparam logic [2:0]  IDX_SHIFT   = 3'h7;
   // ==========================================================
   // Transmit framing
   localparam int          DIF_BYTES   = 80;
   localparam int          PAY_BYTES   = 480;
   localparam int          PAYDIF_BYTES = 400;
   localparam logic [6:0]  HDR_QUADS   = 7'h03;
   localparam logic [6:0]  DIF_QUADS   = 7'(DIF_BYTES / 4);
   localparam logic [6:0]  PAY_FULL    = 7'(PAY_BYTES / 4);
   localparam logic [6:0]  PAY_DIF     = 7'(PAYDIF_BYTES / 4);
   localparam logic [6:0]  PASS_LEN    = 7'(PAY_BYTES / 4 + 3);
   localparam logic [4:0]  PKTS_PER_SEQ = 5'h19;
   localparam logic [3:0]  SEQ_MAX_NTSC = 4'h9;
   localparam logic [3:0]  SEQ_MAX_PAL  = 4'hb;
   localparam int          SEQ_LSB     = 20;
   localparam logic [31:0] DIF_FILL    = 32'hffffffff;
   localparam logic [31:0] DIF_WORD_RST = 32'h00000000;
   typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DIF, TX_PAY} isohp_tx_e;
endpackage

//--- rtl/isohp_tx_if.sv
// Signals between the top and the transmit header inserter
`timescale 1ns/1ps
interface isohp_tx_if;
   logic        insert_mode;
   logic [1:0]  fmt;
   logic        pal;
   logic [31:0] iso_hdr;
   logic [31:0] cip0;
   logic [31:0] cip1;
   logic        word_a_wr;
   logic        word_b_wr;
   logic [31:0] word_data;
   logic        start;
   logic        app_valid;
   logic [31:0] app_data;
   logic        app_ready;
   logic        tx_valid;
   logic [31:0] tx_data;
   logic        tx_sop;
   logic        tx_eop;
   logic [3:0]  seq;
   modport core (input insert_mode, fmt, pal, iso_hdr, cip0, cip1, word_a_wr, word_b_wr,
                 word_data, start, app_valid, app_data,
                 output app_ready, tx_valid, tx_data, tx_sop, tx_eop, seq);
   modport top (output insert_mode, fmt, pal, iso_hdr, cip0, cip1, word_a_wr, word_b_wr,
                word_data, start, app_valid, app_data,
                input app_ready, tx_valid, tx_data, tx_sop, tx_eop, seq);
endinterface

//--- rtl/isohp_tx_insert.sv
// Transmit framing with header block insertion and sequence count
`timescale 1ns/1ps
module isohp_tx_insert (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Transmit group
   isohp_tx_if.core t
);
   import isohp_pkg::*;
   isohp_tx_e   st_q, st_d;
   logic [6:0]  cnt_q, cnt_d;
   logic [4:0]  pkt_q, pkt_d;
   logic [3:0]  seq_q, seq_d;
   logic [31:0] wa_q, wa_d;
   logic [31:0] wb_q, wb_d;
   logic [31:0] dat_q, dat_d;
   logic        v_q, v_d;
   logic        sop_q, sop_d;
   logic        eop_q, eop_d;
   logic        rdy_q, rdy_d;
   logic        dif_pkt;
   logic [6:0]  plen;
   logic [31:0] dw;

   // ==========================================================
   // Next state
   always_comb
   begin
      st_d  = st_q;
      cnt_d = cnt_q;
      pkt_d = pkt_q;
      seq_d = seq_q;
      dat_d = dat_q;
      v_d   = 1'b0;
      sop_d = 1'b0;
      eop_d = 1'b0;
      wa_d  = t.word_a_wr ? t.word_data : wa_q;
      wb_d  = t.word_b_wr ? t.word_data : wb_q;
      dif_pkt = t.insert_mode && (t.fmt == FMT_DV) && (pkt_q == 5'h00);
      plen  = !t.insert_mode ? PASS_LEN : (dif_pkt ? PAY_DIF : PAY_FULL);
      dw    = wa_q;
      dw[SEQ_LSB +: 4] = seq_q;
      case (st_q)
         TX_IDLE:
         begin
            if (t.start)
            begin
               cnt_d = 7'h00;
               st_d  = t.insert_mode ? TX_HDR : TX_PAY;
            end
         end
         TX_HDR:
         begin
            v_d   = 1'b1;
            sop_d = (cnt_q == 7'h00);
            dat_d = (cnt_q == 7'h00) ? t.iso_hdr : ((cnt_q == 7'h01) ? t.cip0 : t.cip1);
            cnt_d = cnt_q + 7'h01;
            if (cnt_q == HDR_QUADS - 7'h01)
            begin
               cnt_d = 7'h00;
               st_d  = dif_pkt ? TX_DIF : TX_PAY;
            end
         end
         TX_DIF:
         begin
            v_d   = 1'b1;
            dat_d = (cnt_q == 7'h00) ? dw : ((cnt_q == 7'h01) ? wb_q : DIF_FILL);
            cnt_d = cnt_q + 7'h01;
            if (cnt_q == DIF_QUADS - 7'h01)
            begin
               cnt_d = 7'h00;
               st_d  = TX_PAY;
            end
         end
         TX_PAY:
         begin
            if (t.app_valid && rdy_q)
            begin
               v_d   = 1'b1;
               dat_d = t.app_data;
               sop_d = !t.insert_mode && (cnt_q == 7'h00);
               cnt_d = cnt_q + 7'h01;
               if (cnt_q == plen - 7'h01)
               begin
                  eop_d = 1'b1;
                  st_d  = TX_IDLE;
                  if (t.insert_mode && (t.fmt == FMT_DV))
                  begin
                     pkt_d = (pkt_q == PKTS_PER_SEQ - 5'h01) ? 5'h00 : pkt_q + 5'h01;
                     if (pkt_q == PKTS_PER_SEQ - 5'h01)
                        seq_d = (seq_q == (t.pal ? SEQ_MAX_PAL : SEQ_MAX_NTSC)) ? 4'h0 : seq_q + 4'h1;
                  end
               end
            end
         end
         default:
            st_d = TX_IDLE;
      endcase
      rdy_d = (st_d == TX_PAY);
   end

   // ==========================================================
   // Registers; only reset clears the sequence state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_q  <= TX_IDLE;
         cnt_q <= 7'h00;
         pkt_q <= 5'h00;
         seq_q <= 4'h0;
         wa_q  <= DIF_WORD_RST;
         wb_q  <= DIF_WORD_RST;
         dat_q <= 32'h00000000;
         v_q   <= 1'b0;
         sop_q <= 1'b0;
         eop_q <= 1'b0;
         rdy_q <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         pkt_q <= pkt_d;
         seq_q <= seq_d;
         wa_q  <= wa_d;
         wb_q  <= wb_d;
         dat_q <= dat_d;
         v_q   <= v_d;
         sop_q <= sop_d;
         eop_q <= eop_d;
         rdy_q <= rdy_d;
      end
   end

   assign t.app_ready = rdy_q;
   assign t.tx_valid  = v_q;
   assign t.tx_data   = dat_q;
   assign t.tx_sop    = sop_q;
   assign t.tx_eop    = eop_q;
   assign t.seq       = seq_q;
endmodule

//--- bench/isohp_monitor.sv
// Concurrent checks on the header path top ports
`timescale 1ns/1ps
module isohp_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Receive side
   input wire logic [1:0]  stream_format_select,
   input wire logic [1:0]  receive_filter_select,
   input wire logic        rx_valid,
   input wire logic [31:0] rx_data,
   input wire logic        rx_sop,
   input wire logic        buf_wr_valid,
   input wire logic [31:0] buf_wr_data,
   input wire logic        buf_wr_eop,
   input wire logic        buf_wr_half,
   input wire logic        rx_pkt_dropped,
   // Transmit side
   input wire logic        header_insert_mode,
   input wire logic        dv_pal_select,
   input wire logic [31:0] tx_iso_header,
   input wire logic [31:0] tx_cip0,
   input wire logic [31:0] tx_cip1,
   input wire logic        tx_start,
   input wire logic        app_valid,
   input wire logic [31:0] app_data,
   input wire logic        app_ready,
   input wire logic        tx_valid,
   input wire logic [31:0] tx_data,
   input wire logic        tx_sop,
   input wire logic        tx_eop,
   input wire logic [3:0]  dif_sequence_id
);
   import isohp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Step sequences
   sequence s_bad_tag;
      rx_valid && rx_sop && stream_format_select == FMT_DV && receive_filter_select == FLT_OFF
         && rx_data[TAG_LSB+:2] != TAG_DV ##1 rx_valid;
   endsequence
   sequence s_cip_pair;
      (tx_valid && tx_data == tx_cip0) ##1 (tx_valid && tx_data == tx_cip1);
   endsequence
   // ==========================================================
   // Assertions
   a_hdr_start_iso: assert property (
      tx_sop && header_insert_mode |-> $past(tx_start, 2) && tx_data == tx_iso_header)
      else $error("packet start without request or header");
   a_cip_pair: assert property (
      tx_sop && header_insert_mode |=> s_cip_pair)
      else $error("CIP quadlets missing after header");
   a_pay_latency: assert property (
      app_valid && app_ready |=> tx_valid && tx_data == $past(app_data))
      else $error("payload word not forwarded next cycle");
   a_eop_ready: assert property (
      tx_eop |-> tx_valid && !app_ready)
      else $error("ready still high at packet end");
   a_seq_step: assert property (
      $changed(dif_sequence_id) |-> dif_sequence_id == $past(dif_sequence_id) + 4'h1
         || (dif_sequence_id == 4'h0
         && $past(dif_sequence_id) == ($past(dv_pal_select) ? SEQ_MAX_PAL : SEQ_MAX_NTSC)))
      else $error("sequence count jumped");
   a_half_flush: assert property (
      buf_wr_half |-> buf_wr_valid && buf_wr_eop && buf_wr_data[15:0] == 16'h0
         && $past(buf_wr_valid) && !$past(buf_wr_eop))
      else $error("bad half quadlet flush");
   a_wr_cause: assert property (
      buf_wr_valid && !buf_wr_half |-> $past(rx_valid, 2))
      else $error("buffer write without received quadlet");
   a_bad_tag_drop: assert property (
      s_bad_tag |=> rx_pkt_dropped)
      else $error("bad tag packet not dropped");
   a_drop_pulse: assert property (
      rx_pkt_dropped |=> !rx_pkt_dropped && !buf_wr_valid)
      else $error("drop pulse too long or data written");
endmodule

//--- bench/isohp_app_model.sv
// Application payload source with random stalls
`timescale 1ns/1ps
module isohp_app_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Bench control
   input  wire logic        halt,
   // Payload handshake
   input  wire logic        app_ready,
   output logic             app_valid,
   output logic [31:0]      app_data
);
   integer      seed = 4;
   logic [23:0] sent;
   logic        go;
   always @(posedge clk)
   begin
      go = (($random(seed) & 15) != 0) && !halt;
      if (!rst_n)
      begin
         app_valid <= 1'b0;
         app_data <= 32'h0;
         sent <= 24'h0;
      end
      else if (!app_valid || app_ready)
      begin
         // Offer held until taken
         if (app_valid)
            sent <= sent + 24'h1;
         app_valid <= go;
         app_data <= go ? {8'hd0, sent + 24'(app_valid)} : ~app_data;
      end
   end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the isochronous header path
`timescale 1ns/1ps
module testbench;
   import isohp_pkg::*;
   logic        clk, rst_n, timestamp_strip_enable, iso_header_strip, first_cip_strip, second_cip_strip;
   logic [1:0]  stream_format_select, receive_filter_select;
   logic [31:0] receive_filter_config_a, receive_filter_config_b, rx_data, tx_iso_header, tx_cip0, tx_cip1;
   logic        rx_valid, rx_sop, rx_eop, buf_wr_valid, buf_wr_eop, buf_wr_half, rx_pkt_dropped;
   logic        header_insert_mode, dv_pal_select, dif_header_word_a_wr, dif_header_word_b_wr, tx_start;
   logic [31:0] dif_header_wdata, app_data, buf_wr_data, tx_data, word_a, word_b;
   logic        app_valid, app_ready, tx_valid, tx_sop, tx_eop, halt;
   logic [3:0]  dif_sequence_id;
   logic [33:0] rxq[$];
   logic [33:0] txq[$];
   integer      seed = 4;
   int          miscompares, check_count, cycles, drops_exp, drops_got, pay_n, pcnt, seq;
   isohp_top dut (.*);
   isohp_app_model u_app (.*);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================================
   // Compare, verdict and output watcher
   task automatic check(input logic [33:0] exp, input logic [33:0] got);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(negedge clk)
   begin
      cycles++;
      if (cycles > 90000)
      begin
         miscompares++;
         conclude();
      end
      else
      begin
         if (buf_wr_valid === 1'b1)
            check(rxq.size() > 0 ? rxq.pop_front() : 'x, {buf_wr_half, buf_wr_eop, buf_wr_data});
         if (tx_valid === 1'b1)
            check(txq.size() > 0 ? txq.pop_front() : 'x, {tx_sop, tx_eop, tx_data});
         if (rx_pkt_dropped === 1'b1)
            drops_got++;
      end
   end
   // ==========================================================
   // Receive packet driver
   task automatic rx_pkt(input int n, input logic [31:0] w0, input logic [31:0] w1, input logic pass);
      logic [31:0] w;
      logic [15:0] held;
      logic        drop;
      for (int i = 0; i < n; i++)
      begin
         w = (i == 0) ? w0 : (i == 1) ? w1 : $random(seed);
         drop = (i == 0 && iso_header_strip) || (i == 1 && first_cip_strip) || (i == 2 && second_cip_strip)
            || (i == 3 && timestamp_strip_enable && iso_header_strip && first_cip_strip && second_cip_strip
            && stream_format_select != FMT_DV);
         if (stream_format_select == FMT_SAT130 && i >= 4)
         begin
            if (i >= 7 && pass)
               rxq.push_back({2'b00, held, w[31:16]});
            held = w[15:0];
         end
         else if (!drop && pass)
            rxq.push_back({1'b0, (i == n - 1), w});
         rx_valid <= 1'b1;
         rx_sop <= (i == 0);
         rx_eop <= (i == n - 1);
         rx_data <= w;
         @(posedge clk);
      end
      if (stream_format_select == FMT_SAT130 && pass)
         rxq.push_back({2'b11, held, 16'h0});
      if (!pass)
         drops_exp++;
      rx_valid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // ==========================================================
   // Transmit packet driver
   task automatic tx_pkt(input logic stall);
      int np;
      np = !header_insert_mode ? 123 : (pcnt == 0) ? 100 : 120;
      tx_start <= 1'b1;
      if (header_insert_mode)
      begin
         txq.push_back({2'b10, tx_iso_header});
         txq.push_back({2'b00, tx_cip0});
         txq.push_back({2'b00, tx_cip1});
         if (pcnt == 0)
         begin
            txq.push_back({2'b00, word_a[31:24], 4'(seq), word_a[19:0]});
            txq.push_back({2'b00, word_b});
            repeat (18) txq.push_back({2'b00, DIF_FILL});
         end
      end
      for (int k = 0; k < np; k++)
         txq.push_back({(!header_insert_mode && k == 0), (k == np - 1), 8'hd0, 24'(pay_n + k)});
      pay_n += np;
      @(posedge clk);
      tx_start <= 1'b0;
      if (stall)
      begin
         // Source stops mid-packet; a start while busy must be ignored
         repeat (40) @(posedge clk);
         halt <= 1'b1;
         tx_start <= 1'b1;
         @(posedge clk);
         tx_start <= 1'b0;
         repeat (150) @(posedge clk);
         halt <= 1'b0;
      end
      while (tx_eop !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      if (header_insert_mode && stream_format_select == FMT_DV)
      begin
         pcnt = (pcnt + 1) % 25;
         if (pcnt == 0)
            seq = (seq == (dv_pal_select ? 11 : 9)) ? 0 : seq + 1;
      end
      repeat (2) @(negedge clk);
      check(34'(seq), {30'h0, dif_sequence_id});
      @(posedge clk);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      {timestamp_strip_enable, iso_header_strip, first_cip_strip, second_cip_strip} = 4'h0;
      {stream_format_select, receive_filter_select} = 4'h0;
      {receive_filter_config_a, receive_filter_config_b, rx_data, dif_header_wdata} = 128'h0;
      {rx_valid, rx_sop, rx_eop, header_insert_mode, dv_pal_select, tx_start, halt} = 7'h0;
      {dif_header_word_a_wr, dif_header_word_b_wr, word_a, word_b} = 66'h0;
      tx_iso_header = $random(seed);
      tx_cip0 = $random(seed);
      tx_cip1 = $random(seed);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check(34'h0, {buf_wr_valid, tx_valid, app_ready, rx_pkt_dropped, dif_sequence_id, 26'h0});
      @(posedge clk);
      for (int m = 0; m < 32; m++)
      begin
         stream_format_select <= m[4] ? FMT_SAT140 : FMT_DV;
         {timestamp_strip_enable, iso_header_strip, first_cip_strip, second_cip_strip} <= m[3:0];
         @(posedge clk);
         rx_pkt(6, $random(seed) & 32'hffff3fff | 32'h00004000, $random(seed), 1'b1);
      end
      stream_format_select <= FMT_DV;
      @(posedge clk);
      rx_pkt(6, 32'h0000c000, 32'h0, 1'b0);
      stream_format_select <= FMT_SAT130;
      for (int m = 0; m < 2; m++)
      begin
         {timestamp_strip_enable, iso_header_strip, first_cip_strip, second_cip_strip} <= m ? 4'hf : 4'h0;
         @(posedge clk);
         rx_pkt(12, $random(seed), $random(seed), 1'b1);
      end
      {timestamp_strip_enable, iso_header_strip, first_cip_strip, second_cip_strip} <= 4'h0;
      stream_format_select <= FMT_SAT140;
      receive_filter_config_a <= 32'h20000000;
      receive_filter_config_b <= 32'h01000000;
      for (int m = 1; m < 4; m++)
      begin
         receive_filter_select <= m[1:0];
         @(posedge clk);
         rx_pkt(5, 32'h21000000, 32'h21000000, 1'b1);
         rx_pkt(5, 32'h01000000, 32'h01000000, 1'b0);
      end
      receive_filter_select <= FLT_OFF;
      stream_format_select <= FMT_DV;
      @(posedge clk);
      tx_pkt(1'b0);
      header_insert_mode <= 1'b1;
      @(posedge clk);
      tx_pkt(1'b0);
      rst_n <= 1'b0;
      {pcnt, pay_n} = 0;
      @(posedge clk);
      rst_n <= 1'b1;
      word_a = $random(seed);
      word_b = $random(seed);
      dif_header_wdata <= word_a;
      dif_header_word_a_wr <= 1'b1;
      @(posedge clk);
      dif_header_wdata <= word_b;
      dif_header_word_a_wr <= 1'b0;
      dif_header_word_b_wr <= 1'b1;
      @(posedge clk);
      dif_header_word_b_wr <= 1'b0;
      for (int p = 1; p < 551; p++)
      begin
         if (p == 251)
            dv_pal_select <= 1'b1;
         tx_pkt(p == 30);
      end
      check(34'(drops_exp), 34'(drops_got));
      check(34'h0, 34'(rxq.size() + txq.size()));
      conclude();
   end
endmodule
bind isohp_top isohp_monitor u_mon (.*);
